// file: rtl/cqi_i2c_port.sv
/*
 * Serial two-wire slave front end of a 32-bit quadrature counter: address
 * match, broadcast writes, register pointer with auto-increment, byte
 * writes to the counter core and byte reads from it.
 * Assumes the core answers rd_data for rd_addr/rd_byte within one clk and
 * takes wr_data on the wr_strobe pulse; SCL runs far slower than clk.
 */
// Function
// - lost high read bit: release, wait START
// - START anywhere restarts at address byte
// - STOP anywhere returns to idle
// - STOP after register byte clears pointer
// - address 0000xxx write hits every device
// - broadcast register byte 3 selects prescale
// - broadcast: acknowledge address, register, data
// - preset pointer advances after configured bytes
// - auto-increment wraps: read 8, write 5
// - multi-byte values go MSB first
// - NACK or STOP ends the transaction
`timescale 1ns/100ps
`default_nettype none
`include "cqi_params.svh"

module cqi_i2c_port
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,
    input  wire logic [2:0] addr_pin,
    input  wire logic [1:0] preset_bytes_m1,
    output logic      [3:0] rd_addr,
    output logic      [1:0] rd_byte,
    input  wire logic [7:0] rd_data,
    output logic            wr_strobe,
    output logic      [3:0] wr_addr,
    output logic      [1:0] wr_byte,
    output logic      [7:0] wr_data
);
    import cqi_pkg::*;

    cqi_state_e state_reg;
    logic [1:0] line_s;
    logic [2:0] pin_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_prev_reg;
    logic       sda_prev_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic       ack_phase_reg;
    logic       is_read_reg;
    logic       autoinc_reg;
    logic       ptr_fresh_reg;
    logic [3:0] ptr_reg;
    logic [1:0] byte_idx_reg;
    logic       oe_n_reg;
    logic       sda_o_reg;
    logic       wr_strobe_reg;
    logic [3:0] wr_addr_reg;
    logic [1:0] wr_byte_reg;
    logic [7:0] wr_data_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [7:0] rx_byte;
    logic       addr_hit;
    logic [3:0] ptr_next;

    // multi-byte registers carry the configured width, all others one byte
    function automatic logic [1:0] last_idx(input logic [3:0] a, input logic [1:0] w);
        last_idx = 2'h0;
        if (a == `CQI_REG_PRESET0 || a == `CQI_REG_PRESET1 ||
            a == `CQI_REG_COUNT || a == `CQI_REG_LATCH)
            last_idx = w;
    endfunction

    function automatic logic [3:0] next_ptr(input logic [3:0] a, input logic rd);
        next_ptr = a + 4'h1;
        if (rd)
        begin
            if (a >= `CQI_REG_LAST_RD)
                next_ptr = `CQI_PTR_RESET;
            else if (a + 4'h1 == `CQI_REG_PRESCALE)
                next_ptr = a + 4'h2;
        end
        else if (a >= `CQI_REG_LAST_WR)
            next_ptr = `CQI_PTR_RESET;
    endfunction

    cqi_sync #(.WIDTH(2), .RST_VAL(`CQI_SYNC_RST)) u_line_sync
    (
        .clk      (clk),
        .reset    (reset),
        .async_in ({scl_i, sda_i}),
        .sync_out (line_s)
    );

    // address straps are static, but still enter through two flops
    cqi_sync #(.WIDTH(3), .RST_VAL(1'b0)) u_pin_sync
    (
        .clk      (clk),
        .reset    (reset),
        .async_in (addr_pin),
        .sync_out (pin_s)
    );

    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            scl_prev_reg <= `CQI_SYNC_RST;
            sda_prev_reg <= `CQI_SYNC_RST;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_prev_reg;
    assign scl_fall  = ~scl_s & scl_prev_reg;
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
    assign rx_byte   = {shift_reg[6:0], sda_s};
    // a broadcast address with the read bit set matches nothing
    assign addr_hit  = (rx_byte[7:4] == `CQI_DEV_ADDR_HI && rx_byte[3:1] == pin_s) ||
                       (rx_byte[7:4] == `CQI_BCAST_HI && !rx_byte[0]);
    assign ptr_next  = next_ptr(ptr_reg, is_read_reg);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg     <= CQI_IDLE;
            bit_cnt_reg   <= 3'h0;
            shift_reg     <= 8'h00;
            ack_phase_reg <= 1'b0;
            is_read_reg   <= 1'b0;
            autoinc_reg   <= 1'b0;
            ptr_fresh_reg <= 1'b0;
            ptr_reg       <= `CQI_PTR_RESET;
            byte_idx_reg  <= 2'h0;
            oe_n_reg      <= 1'b1;
            wr_strobe_reg <= 1'b0;
            wr_addr_reg   <= 4'h0;
            wr_byte_reg   <= 2'h0;
            wr_data_reg   <= 8'h00;
        end
        else
        begin
            wr_strobe_reg <= 1'b0;
            if (start_det)
            begin
                state_reg     <= CQI_ADDR;
                bit_cnt_reg   <= 3'h0;
                oe_n_reg      <= 1'b1;
                ack_phase_reg <= 1'b0;
                ptr_fresh_reg <= 1'b0;
            end
            else if (stop_det)
            begin
                state_reg     <= CQI_IDLE;
                oe_n_reg      <= 1'b1;
                ack_phase_reg <= 1'b0;
                ptr_fresh_reg <= 1'b0;
                if (ptr_fresh_reg)
                begin
                    ptr_reg      <= `CQI_PTR_RESET;
                    byte_idx_reg <= 2'h0;
                end
            end
            else
            begin
                case (state_reg)
                    CQI_IDLE:
                    begin
                    end
                    CQI_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg   <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == `CQI_LAST_BIT)
                            begin
                                is_read_reg <= rx_byte[0];
                                state_reg   <= addr_hit ? CQI_ADDR_ACK : CQI_IDLE;
                            end
                        end
                    end
                    CQI_ADDR_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (!ack_phase_reg)
                            begin
                                oe_n_reg      <= 1'b0;
                                ack_phase_reg <= 1'b1;
                            end
                            else
                            begin
                                ack_phase_reg <= 1'b0;
                                bit_cnt_reg   <= 3'h0;
                                if (is_read_reg)
                                begin
                                    shift_reg <= rd_data;
                                    oe_n_reg  <= rd_data[7];
                                    state_reg <= CQI_RDATA;
                                end
                                else
                                begin
                                    oe_n_reg  <= 1'b1;
                                    state_reg <= CQI_REG;
                                end
                            end
                        end
                    end
                    CQI_REG:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg   <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == `CQI_LAST_BIT)
                            begin
                                ptr_reg       <= rx_byte[3:0];
                                autoinc_reg   <= rx_byte[`CQI_AUTOINC_BIT];
                                byte_idx_reg  <= last_idx(rx_byte[3:0], preset_bytes_m1);
                                ptr_fresh_reg <= 1'b1;
                                state_reg     <= CQI_WACK;
                            end
                        end
                    end
                    CQI_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg   <= rx_byte;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == `CQI_LAST_BIT)
                            begin
                                wr_strobe_reg <= 1'b1;
                                wr_addr_reg   <= ptr_reg;
                                wr_byte_reg   <= byte_idx_reg;
                                wr_data_reg   <= rx_byte;
                                ptr_fresh_reg <= 1'b0;
                                state_reg     <= CQI_WACK;
                                if (byte_idx_reg != 2'h0)
                                    byte_idx_reg <= byte_idx_reg - 2'h1;
                                else if (autoinc_reg)
                                begin
                                    ptr_reg      <= ptr_next;
                                    byte_idx_reg <= last_idx(ptr_next, preset_bytes_m1);
                                end
                                else
                                    byte_idx_reg <= last_idx(ptr_reg, preset_bytes_m1);
                            end
                        end
                    end
                    CQI_WACK:
                    begin
                        if (scl_fall)
                        begin
                            if (!ack_phase_reg)
                            begin
                                oe_n_reg      <= 1'b0;
                                ack_phase_reg <= 1'b1;
                            end
                            else
                            begin
                                oe_n_reg      <= 1'b1;
                                ack_phase_reg <= 1'b0;
                                bit_cnt_reg   <= 3'h0;
                                state_reg     <= CQI_WDATA;
                            end
                        end
                    end
                    CQI_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            if (oe_n_reg && !sda_s)
                                state_reg <= CQI_IDLE;
                            else
                            begin
                                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                                if (bit_cnt_reg == `CQI_LAST_BIT)
                                    state_reg <= CQI_RACK;
                            end
                        end
                        else if (scl_fall)
                        begin
                            oe_n_reg  <= shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        end
                    end
                    CQI_RACK:
                    begin
                        if (scl_fall)
                            oe_n_reg <= 1'b1;
                        else if (scl_rise)
                        begin
                            if (sda_s)
                                state_reg <= CQI_IDLE;
                            else
                            begin
                                state_reg <= CQI_RNEXT;
                                if (byte_idx_reg != 2'h0)
                                    byte_idx_reg <= byte_idx_reg - 2'h1;
                                else if (autoinc_reg)
                                begin
                                    ptr_reg      <= ptr_next;
                                    byte_idx_reg <= last_idx(ptr_next, preset_bytes_m1);
                                end
                                else
                                    byte_idx_reg <= last_idx(ptr_reg, preset_bytes_m1);
                            end
                        end
                    end
                    CQI_RNEXT:
                    begin
                        if (scl_fall)
                        begin
                            shift_reg   <= rd_data;
                            oe_n_reg    <= rd_data[7];
                            bit_cnt_reg <= 3'h0;
                            state_reg   <= CQI_RDATA;
                        end
                    end
                    default:
                        state_reg <= CQI_IDLE;
                endcase
            end
        end
    end

    // open drain: the data level is always low, only the enable moves
    always_ff @(posedge clk)
    begin
        if (reset)
            sda_o_reg <= 1'b0;
        else
            sda_o_reg <= 1'b0;
    end

    assign sda_o     = sda_o_reg;
    assign sda_oe_n  = oe_n_reg;
    assign rd_addr   = ptr_reg;
    assign rd_byte   = byte_idx_reg;
    assign wr_strobe = wr_strobe_reg;
    assign wr_addr   = wr_addr_reg;
    assign wr_byte   = wr_byte_reg;
    assign wr_data   = wr_data_reg;

endmodule

`default_nettype wire

// file: pkg/cqi_params.svh
/*
 * Constants of the counter serial register port: slave address fields,
 * register pointer values and wrap points.
 * Assumes it is included by bare name from the port's design files.
 */
`ifndef CQI_PARAMS_SVH
`define CQI_PARAMS_SVH

`define CQI_DEV_ADDR_HI   4'hE
`define CQI_BCAST_HI      4'h0
`define CQI_PTR_RESET     4'h0
`define CQI_REG_PRESCALE  4'h3
`define CQI_REG_PRESET0   4'h4
`define CQI_REG_PRESET1   4'h5
`define CQI_REG_COUNT     4'h6
`define CQI_REG_LATCH     4'h7
`define CQI_REG_LAST_RD   4'h8
`define CQI_REG_LAST_WR   4'h5
`define CQI_AUTOINC_BIT   4
`define CQI_LAST_BIT      3'h7
`define CQI_SYNC_RST      1'b1

`endif

// file: pkg/cqi_pkg.sv
/*
 * Types of the counter serial register port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package cqi_pkg;

    typedef enum logic [3:0] {
        CQI_IDLE,
        CQI_ADDR,
        CQI_ADDR_ACK,
        CQI_REG,
        CQI_WDATA,
        CQI_WACK,
        CQI_RDATA,
        CQI_RACK,
        CQI_RNEXT
    } cqi_state_e;

endpackage

`default_nettype wire

// file: rtl/cqi_sync.sv
/*
 * Two flip-flop synchroniser for a group of asynchronous input levels.
 * Assumes the inputs are levels from outside the clk domain.
 */
`timescale 1ns/100ps
`default_nettype none

module cqi_sync
#(
    parameter int         WIDTH   = 1,
    parameter logic       RST_VAL = 1'b0
)
(
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta_reg <= {WIDTH{RST_VAL}};
            sync_reg <= {WIDTH{RST_VAL}};
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// file: tb/cqi_i2c_port_chk.sv
/* assertions on the port pins and the core write strobe
   assumes binding into cqi_i2c_port; scl runs far slower than clk */
`timescale 1ns/100ps
`default_nettype none

module cqi_i2c_port_chk
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_oe_n,
    input wire logic [1:0] preset_bytes_m1,
    input wire logic       wr_strobe,
    input wire logic [3:0] wr_addr,
    input wire logic [1:0] wr_byte
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic       mid_reg;
    logic [5:0] last_reg;
    wire        start_seen = scl_q[2] & scl_q[1] & sda_q[2] & ~sda_q[1];
    wire        stop_seen = scl_q[2] & scl_q[1] & ~sda_q[2] & sda_q[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // same sync depth as the port, so events line up with its own view
    always_ff @(posedge clk)
    begin
        scl_q <= {scl_q[1:0], scl_i};
        sda_q <= {sda_q[1:0], sda_i};
    end
    always_ff @(posedge clk)
    begin
        if (reset || start_seen)
            mid_reg <= 1'b0;
        else if (wr_strobe)
            mid_reg <= wr_byte != 2'h0;
    end
    always_ff @(posedge clk)
    begin
        if (wr_strobe)
            last_reg <= {wr_addr, wr_byte};
    end

    a_reset_idle: assert property ($fell(reset) |-> (sda_oe_n && !wr_strobe) [*3])
        else $error("port active right after reset");
    a_start_quiet: assert property (start_seen |=> sda_oe_n [*8])
        else $error("port drove sda during a fresh address byte");
    a_stop_idle: assert property (stop_seen |=> (sda_oe_n && !wr_strobe) [*6])
        else $error("port active after a stop");
    a_strobe_single: assert property (wr_strobe |=> !wr_strobe [*8])
        else $error("more than one write per byte");
    a_first_msb: assert property (wr_strobe && !mid_reg && wr_addr inside {[4'h4:4'h7]}
        |-> wr_byte == preset_bytes_m1)
        else $error("multi-byte write did not start at the top byte");
    a_msb_order: assert property (wr_strobe && mid_reg
        |-> {wr_addr, wr_byte} == {last_reg[5:2], last_reg[1:0] - 2'h1})
        else $error("multi-byte write out of order");
    a_drive_hold: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*5])
        else $error("low drive on sda too short");
    a_scl_low_move: assert property ($changed(sda_oe_n) |-> !scl_q[2])
        else $error("sda drive changed while scl high");
endmodule

bind cqi_i2c_port cqi_i2c_port_chk i_cqi_i2c_port_chk
(
    .clk(clk), .reset(reset), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_n(sda_oe_n),
    .preset_bytes_m1(preset_bytes_m1), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_byte(wr_byte)
);

`default_nettype wire

// file: tb/cqi_bus_master.sv
/* bus master model: drives scl and its side of sda, one bit per 8 clk
   assumes sda_w is the resolved open-drain wire with a pull-up */
`timescale 1ns/100ps
`default_nettype none

module cqi_bus_master
(
    input  wire logic clk,
    input  wire logic sda_w,
    output logic      scl = 1'b1,
    output logic      sda_m = 1'b1
);
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // long low phase: the slave's delayed drive settles before scl rises
    task automatic bit_x(input logic b, output logic s);
        sda_m <= b;
        tick(4);
        scl <= 1'b1;
        tick(1);
        s = sda_w;
        tick(1);
        scl <= 1'b0;
        tick(2);
    endtask
    // sda moves only after the slave has let go of it
    task automatic start();
        sda_m <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(2);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_m <= 1'b1;
        tick(6);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_x(tx[i], rx[i]);
        bit_x(last, ack);
    endtask
endmodule

`default_nettype wire

// file: tb/cqi_i2c_port_test.sv
/* self-checking bench for the serial register port with a core model
   assumes cqi_bus_master and the bound checker are compiled with it */
`timescale 1ns/100ps
`default_nettype none
`include "cqi_params.svh"

module cqi_i2c_port_test;
    localparam logic [7:0] DEV_W = {`CQI_DEV_ADDR_HI, 3'h5, 1'b0};
    localparam logic [7:0] DEV_R = DEV_W | 8'h01;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        scl, sda_m, sda_o, sda_oe_n, wr_strobe;
    logic [2:0]  addr_pin = 3'h5;
    logic [1:0]  preset_bytes_m1 = 2'h1;
    logic [1:0]  rd_byte, wr_byte;
    logic [3:0]  rd_addr, wr_addr;
    logic [7:0]  rd_data = 8'h00;
    logic [7:0]  wr_data;
    logic [13:0] wq[$];
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    wire         sda_w = sda_m & (sda_oe_n | sda_o);

    cqi_i2c_port i_cqi_i2c_port
    (
        .clk(clk), .reset(reset), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .addr_pin(addr_pin), .preset_bytes_m1(preset_bytes_m1),
        .rd_addr(rd_addr), .rd_byte(rd_byte), .rd_data(rd_data), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_byte(wr_byte), .wr_data(wr_data)
    );
    cqi_bus_master i_cqi_bus_master (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

    initial
    begin
        forever #25 clk = ~clk;
    end
    // core model: each byte encodes its own register and index
    function automatic logic [7:0] rv(input logic [3:0] a, input logic [1:0] b);
        return {~a, 2'b10, b};
    endfunction
    always @(posedge clk)
    begin
        rd_data <= rv(rd_addr, rd_byte);
        if (wr_strobe === 1'b1)
            wq.push_back({wr_addr, wr_byte, wr_data});
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(input logic [7:0] d, input logic ack);
        logic [7:0] rx;
        logic       line;
        i_cqi_bus_master.xfer(d, 1'b1, rx, line);
        chk("ack", {13'h0, ack}, {13'h0, ~line});
    endtask
    task automatic get(input logic last, input logic [7:0] exp);
        logic [7:0] rx;
        logic       line;
        i_cqi_bus_master.xfer(8'hFF, last, rx, line);
        chk("read", {6'h0, exp}, {6'h0, rx});
    endtask
    task automatic wexp(input logic [13:0] e);
        logic [13:0] got;
        got = wq.size() > 0 ? wq.pop_front() : 'x;
        chk("write", e, got);
    endtask
    task automatic wr_head(input logic [7:0] r);
        i_cqi_bus_master.start();
        put(DEV_W, 1'b1);
        put(r, 1'b1);
    endtask

    task automatic t_abort();
        logic s;
        i_cqi_bus_master.start();
        put(DEV_W, 1'b1);
        repeat (4) i_cqi_bus_master.bit_x(1'b0, s);
        wr_head(8'h01);
        put(8'h3C, 1'b1);
        repeat (3) i_cqi_bus_master.bit_x(1'b1, s);
        i_cqi_bus_master.stop();
        wexp({4'h1, 2'h0, 8'h3C});
        chk("writes left", 14'h0, 14'(wq.size()));
    endtask
    task automatic t_autoinc();
        preset_bytes_m1 <= 2'h3;
        wr_head(8'h15);
        for (int i = 0; i < 6; i++)
            put(8'(8'h11 * (i + 1)), 1'b1);
        i_cqi_bus_master.stop();
        for (int i = 0; i < 6; i++)
            wexp({i < 4 ? 4'h5 : 4'(i - 4), i < 4 ? 2'(3 - i) : 2'h0, 8'(8'h11 * (i + 1))});
    endtask
    task automatic t_bcast();
        i_cqi_bus_master.start();
        put(8'h0C, 1'b1);
        put(8'h03, 1'b1);
        put(8'h7E, 1'b1);
        i_cqi_bus_master.stop();
        wexp({4'h3, 2'h0, 8'h7E});
        i_cqi_bus_master.start();
        put(8'h0D, 1'b0);
        i_cqi_bus_master.stop();
        i_cqi_bus_master.start();
        put(8'hE4, 1'b0);
        i_cqi_bus_master.stop();
    endtask
    task automatic t_read();
        preset_bytes_m1 <= 2'h1;
        wr_head(8'h12);
        i_cqi_bus_master.start();
        put(DEV_R, 1'b1);
        get(1'b0, rv(4'h2, 2'h0));
        get(1'b0, rv(4'h4, 2'h1));
        get(1'b0, rv(4'h4, 2'h0));
        get(1'b1, rv(4'h5, 2'h1));
        get(1'b1, 8'hFF);
        i_cqi_bus_master.stop();
        wr_head(8'h18);
        i_cqi_bus_master.start();
        put(DEV_R, 1'b1);
        get(1'b0, rv(4'h8, 2'h0));
        get(1'b1, rv(4'h0, 2'h0));
        i_cqi_bus_master.stop();
    endtask
    task automatic t_ptr_clear();
        wr_head(8'h07);
        i_cqi_bus_master.stop();
        chk("pointer", 14'h0, {10'h0, rd_addr});
        i_cqi_bus_master.start();
        put(DEV_R, 1'b1);
        get(1'b1, rv(4'h0, 2'h0));
        i_cqi_bus_master.stop();
    endtask
    task automatic t_arb();
        logic       s;
        logic [6:0] rest;
        wr_head(8'h01);
        i_cqi_bus_master.start();
        put(DEV_R, 1'b1);
        i_cqi_bus_master.bit_x(1'b0, s);
        for (int i = 6; i >= 0; i--)
            i_cqi_bus_master.bit_x(1'b1, rest[i]);
        i_cqi_bus_master.bit_x(1'b1, s);
        i_cqi_bus_master.stop();
        chk("lost read", 14'h7F, {7'h0, rest});
        chk("writes left", 14'h0, 14'(wq.size()));
        chk("sda data", 14'h0, {13'h0, sda_o});
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_abort();
        t_autoinc();
        t_bcast();
        t_read();
        t_ptr_clear();
        t_arb();
        wrap_up();
    end
endmodule

`default_nettype wire
